// >>> shared/ssi_pkg.sv
// Constants and types for the serial switch-input monitor.
// Assumes a single system clock; all pin timing is expressed in its cycles.
package ssi_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SSI_WIDTH_WIDE   = 16;
    localparam int SSI_WIDTH_NARROW = 8;
    localparam int SSI_SYNC_STAGES  = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SSI_CLK_HZ       = 10_000_000;
    localparam int SSI_SCLK_MAX_HZ  = 5_000_000;
    // Least high or low time of the serial clock, rounded down.
    localparam int SSI_SCLK_HALF_CYC_RAW = SSI_CLK_HZ / (2 * SSI_SCLK_MAX_HZ);
    localparam int SSI_SCLK_HALF_CYC = (SSI_SCLK_HALF_CYC_RAW < 1) ? 1 : SSI_SCLK_HALF_CYC_RAW;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic SSI_CS_RST     = 1'b1;
    localparam logic SSI_SCLK_RST   = 1'b0;
    localparam logic SSI_SIN_RST    = 1'b0;
    localparam logic SSI_INT_DRIVE  = 1'b0;

    // ------------------------------------------------------------
    // Frame states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSI_IDLE  = 2'h0,
        SSI_ARMED = 2'h1,
        SSI_SHIFT = 2'h3
    } ssi_state_t;

endpackage : ssi_pkg

// >>> verilog/ssi_buf2.sv
// Two-entry word buffer with valid and ready on both sides.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module ssi_buf2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock_in,     // System clock.
    input  wire logic             rst_in,       // Asynchronous reset.
    input  wire logic             in_valid_in,  // Write offered.
    output logic                  in_ready_out, // Room for a word.
    input  wire logic [WIDTH-1:0] in_data_in,   // Word written.
    output logic                  out_valid_out,// Word available.
    input  wire logic             out_ready_in, // Reader takes word.
    output logic      [WIDTH-1:0] out_data_out  // Oldest word, registered.
);
    import ssi_pkg::*;

    logic [WIDTH-1:0] slot1_r;
    logic [1:0]       count_r;
    logic             push;
    logic             pop;

    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= 2'h0;
        end else begin
            count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
        end
    end

    assign in_ready_out  = (count_r != 2'h2);
    assign out_valid_out = (count_r != 2'h0);

    // Slot 0 is the head and is held in out_data_out itself.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            out_data_out <= '0;
            slot1_r      <= '0;
        end else begin
            if (pop) begin
                out_data_out <= (count_r == 2'h2) ? slot1_r : in_data_in;
            end else if (push && count_r == 2'h0) begin
                out_data_out <= in_data_in;
            end
            if (push && ((count_r == 2'h1 && !pop) || count_r == 2'h2)) begin
                slot1_r <= in_data_in;
            end
        end
    end

endmodule : ssi_buf2

// >>> verilog/ssi_top.sv
// Serial switch-input monitor: snapshot, serial readout and change interrupt.
// Assumes every pin input is asynchronous to clock_in and the serial clock
// runs no faster than half of clock_in.
`timescale 1ns/1ns
module ssi_top #(
    parameter int WIDTH = ssi_pkg::SSI_WIDTH_WIDE
) (
    input  wire logic             clock_in,          // System clock, 10 MHz.
    input  wire logic             rst_in,            // Asynchronous reset, active high.
    input  wire logic [WIDTH-1:0] switch_input_in,   // Monitored switch levels.
    input  wire logic             chip_sel_n_in,     // Chip select, active low.
    input  wire logic             sclk_in,           // Serial clock pin.
    input  wire logic             serial_in_in,      // Serial data input pin.
    input  wire logic             int_enable_in,     // Interrupt output enable.
    output logic                  serial_out_out,    // Serial data output level.
    output logic                  serial_oe_out,     // Serial output drive enable.
    output logic                  int_n_out,         // Interrupt pin level when driven.
    output logic                  int_oe_out         // Interrupt pull-down enable.
);
    import ssi_pkg::*;

    localparam int NSYNC = WIDTH + 4;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic [NSYNC-1:0] pin_vec;
    logic [NSYNC-1:0] rst_vec;

    assign pin_vec = {int_enable_in, serial_in_in, sclk_in, chip_sel_n_in, switch_input_in};
    // A released serial input settles low, so the synchroniser starts low too.
    assign rst_vec = {1'b0, SSI_SIN_RST, SSI_SCLK_RST, SSI_CS_RST, {WIDTH{1'b0}}};

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= pin_vec[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    logic [WIDTH-1:0] sw_s;
    logic             cs_s;
    logic             sclk_s;
    logic             sin_s;
    logic             en_s;
    logic             init_r;

    // Until the second post-reset edge the synchroniser holds zeros; the
    // idle levels are substituted so no false edge is seen.
    assign sw_s   = sync_r[WIDTH-1:0];
    assign cs_s   = init_r ? sync_r[WIDTH]   : rst_vec[WIDTH];
    assign sclk_s = init_r ? sync_r[WIDTH+1] : rst_vec[WIDTH+1];
    assign sin_s  = init_r ? sync_r[WIDTH+2] : rst_vec[WIDTH+2];
    assign en_s   = sync_r[WIDTH+3];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic [1:0] init_cnt_r;
    logic       cs_prev_r;
    logic       sclk_prev_r;
    logic       cs_fall;
    logic       cs_rise;
    logic       sclk_rise;
    logic       sclk_fall;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            init_cnt_r <= 2'h0;
            init_r     <= 1'b0;
        end else begin
            if (init_cnt_r != 2'(SSI_SYNC_STAGES)) begin
                init_cnt_r <= 2'(init_cnt_r + 2'h1);
            end
            init_r <= (init_cnt_r == 2'(SSI_SYNC_STAGES));
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cs_prev_r   <= SSI_CS_RST;
            sclk_prev_r <= SSI_SCLK_RST;
        end else begin
            cs_prev_r   <= cs_s;
            sclk_prev_r <= sclk_s;
        end
    end

    assign cs_fall   = cs_prev_r && !cs_s;
    assign cs_rise   = !cs_prev_r && cs_s;
    // Serial clock edges count only inside a frame.
    assign sclk_rise = !cs_s && !sclk_prev_r && sclk_s;
    assign sclk_fall = !cs_s && sclk_prev_r && !sclk_s;

    // ------------------------------------------------------------
    // Snapshot and frame state
    // ------------------------------------------------------------
    logic [WIDTH-1:0] status_r;
    ssi_state_t       state_r;
    ssi_state_t       state_nxt;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            status_r <= '0;
        end else if (cs_fall) begin
            status_r <= sw_s;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SSI_IDLE:  state_nxt = cs_fall ? SSI_ARMED : SSI_IDLE;
            SSI_ARMED: state_nxt = cs_s ? SSI_IDLE : (sclk_rise ? SSI_SHIFT : SSI_ARMED);
            SSI_SHIFT: state_nxt = cs_s ? SSI_IDLE : SSI_SHIFT;
            default:   state_nxt = SSI_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= SSI_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Snapshot buffer
    // ------------------------------------------------------------
    // Each frame pushes its snapshot if the buffer is empty; the first rising edge takes it, and a
    // frame that never clocks drops its word at deselect, unless deselect falls in its push cycle:
    // that word then stays, and the next frame's first rising edge loads it in place of its own.
    logic             buf_in_ready;
    logic             buf_out_valid;
    logic [WIDTH-1:0] buf_out_data;
    logic             load;

    assign load = (state_r == SSI_ARMED) && sclk_rise && buf_out_valid;

    ssi_buf2 #(.WIDTH(WIDTH)) u_buf (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .in_valid_in   (state_r == SSI_ARMED && !cs_prev_r && !buf_out_valid),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (status_r),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (load || (cs_rise && buf_out_valid)),
        .out_data_out  (buf_out_data)
    );

    // ------------------------------------------------------------
    // Shift register and serial output
    // ------------------------------------------------------------
    logic [WIDTH-1:0] shift_r;
    logic [WIDTH-1:0] shift_nxt;
    logic             sample_r;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sample_r <= SSI_SIN_RST;
        end else if (sclk_fall) begin
            sample_r <= sin_s;
        end
    end

    always_comb begin
        shift_nxt = shift_r;
        if (state_r == SSI_ARMED && sclk_rise) begin
            shift_nxt = buf_out_valid ? buf_out_data : status_r;
        end else if (state_r == SSI_SHIFT && sclk_rise) begin
            shift_nxt = {shift_r[WIDTH-2:0], sample_r};
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            shift_r        <= '0;
            serial_out_out <= 1'b0;
            serial_oe_out  <= 1'b0;
        end else begin
            shift_r        <= shift_nxt;
            serial_out_out <= shift_nxt[WIDTH-1];
            serial_oe_out  <= !cs_s;
        end
    end

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // The snapshot write on select is what clears the interrupt, so no
    // separate clear path can race a fresh change.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            int_oe_out <= 1'b0;
            int_n_out  <= SSI_INT_DRIVE;
        end else begin
            int_oe_out <= en_s && (sw_s != status_r);
            int_n_out  <= SSI_INT_DRIVE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    AST_INT_DIFF: assert property ((en_s && sw_s != status_r) |=> int_oe_out)
        else $error("interrupt not asserted on mismatch");
    AST_INT_MATCH: assert property ((sw_s == status_r) |=> !int_oe_out)
        else $error("interrupt asserted without mismatch");
    AST_CAPTURE: assert property (cs_fall |=> status_r == $past(sw_s))
        else $error("snapshot not captured on select");
    AST_CLEAR: assert property (cs_fall ##1 (sw_s == status_r) |=> !int_oe_out)
        else $error("interrupt not cleared after select");
    AST_OPEN_DRAIN: assert property (int_n_out == 1'b0)
        else $error("interrupt pin would drive high");
    AST_EN_OFF: assert property (!en_s |=> !int_oe_out)
        else $error("interrupt driven while disabled");
    AST_SO_RELEASE: assert property (cs_s |=> !serial_oe_out)
        else $error("serial output driven while deselected");
    AST_LOAD: assert property ((state_r == SSI_ARMED && sclk_rise)
        |=> serial_out_out == $past(status_r[WIDTH-1]) && state_r == SSI_SHIFT)
        else $error("first rising edge did not load snapshot");
    AST_SHIFT: assert property ((state_r == SSI_SHIFT && sclk_rise && !cs_s)
        |=> serial_out_out == $past(shift_r[WIDTH-2]))
        else $error("shift did not present next bit");
    AST_SAMPLE: assert property (sclk_fall |=> sample_r == $past(sin_s))
        else $error("serial input not sampled");
    AST_HOLD: assert property ((cs_s && cs_prev_r) [*2] |=> $stable(shift_r))
        else $error("shift register moved while deselected");

    COV_LOAD: cover property (state_r == SSI_ARMED && sclk_rise);
    COV_SHIFT: cover property ((state_r == SSI_SHIFT && sclk_rise) ##[1:8] sclk_fall);
    COV_INT: cover property (int_oe_out ##1 cs_fall);

endmodule : ssi_top

// >>> verif/ssi_spi_ctrl.sv
// SPI controller model that reads the serial switch-input monitor.
// Assumes the bench feeds it the resolved serial output wire.
`timescale 1ns/1ns
module ssi_spi_ctrl (
    output logic      chip_sel_n_out, // Chip select, active low.
    output logic      sclk_out,       // Serial clock.
    output logic      serial_in_out,  // Data towards the monitor.
    input  wire logic sdo_in          // Resolved serial output wire.
);
    initial begin
        chip_sel_n_out = 1'b1;
        sclk_out       = 1'b0;
        serial_in_out  = 1'b0;
    end

    // The clock is parked low before either select edge.
    task automatic select(input logic on);
        sclk_out       = 1'b0;
        chip_sel_n_out = !on;
        #(1000);
    endtask : select

    // Half periods of 400 ns or more keep the clock well under 5 MHz.
    // Data is read just before the next rise, where the output surely stands.
    task automatic xfer(input int nbits, input logic [31:0] tx, input int half,
                        output logic [31:0] rx);
        rx = '0;
        for (int i = 0; i < nbits; i++) begin
            sclk_out = 1'b1;
            #(half / 2);
            serial_in_out = tx[nbits-1-i];
            #(half - half / 2);
            sclk_out = 1'b0;
            #(half);
            rx = {rx[30:0], sdo_in};
        end
        serial_in_out = 1'b0;
    endtask : xfer

    // Clock and data activity while deselected.
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            sclk_out      = 1'b1;
            serial_in_out = 1'b1;
            #(400);
            sclk_out      = 1'b0;
            serial_in_out = 1'b0;
            #(400);
        end
    endtask : noise
endmodule : ssi_spi_ctrl

// >>> verif/spi_switch_input_shifter_irq_tb.sv
// Self-checking bench for the serial switch-input monitor.
// Assumes the controller model in ssi_spi_ctrl and pull-up on the interrupt wire.
`timescale 1ns/1ns
module spi_switch_input_shifter_irq_tb;
    import ssi_pkg::*;
    localparam int W = SSI_WIDTH_WIDE;
    logic          clock_in;
    logic          rst_in;
    logic          int_enable;
    logic [W-1:0]  sw;
    logic          cs_n;
    logic          sclk;
    logic          serial_in;
    logic          sout;
    logic          soe;
    logic          int_n;
    logic          int_oe;
    logic          last_sout = 1'b0;
    logic [31:0]   rx;
    int            num_errors = 0;
    int            checks     = 0;
    // A released data line shows the inverse of its last level, not a held copy.
    wire           sdo_wire = soe ? sout : !last_sout;
    wire           int_wire = int_oe ? int_n : 1'b1;

    ssi_top #(.WIDTH(W)) DUT (
        .clock_in(clock_in), .rst_in(rst_in), .switch_input_in(sw),
        .chip_sel_n_in(cs_n), .sclk_in(sclk), .serial_in_in(serial_in),
        .int_enable_in(int_enable), .serial_out_out(sout), .serial_oe_out(soe),
        .int_n_out(int_n), .int_oe_out(int_oe)
    );
    ssi_spi_ctrl PEER (
        .chip_sel_n_out(cs_n), .sclk_out(sclk), .serial_in_out(serial_in), .sdo_in(sdo_wire)
    );

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = !clock_in;
    end
    always @(posedge clock_in) begin
        if (soe) last_sout <= sout;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    task automatic check_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask : check_bit
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check_word
    task automatic stop_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle;
        check_bit(soe, 1'b0, "output driven while idle");
        check_bit(int_wire, 1'b1, "interrupt with no change");
        $display("test idle done");
    endtask : t_idle

    task automatic t_read(input logic [W-1:0] v, input int half);
        sw = v;
        tick(6);
        PEER.select(1'b1);
        check_bit(soe, 1'b1, "output not driven in frame");
        PEER.xfer(W, 32'h0, half, rx);
        check_word(rx[W-1:0], v, "readback");
        PEER.select(1'b0);
        check_bit(soe, 1'b0, "output driven after frame");
        $display("test read %h done", v);
    endtask : t_read

    task automatic t_chain;
        sw = 16'h8001;
        tick(6);
        PEER.select(1'b1);
        PEER.xfer(W + 8, 32'hB40000, 400, rx);
        check_word(rx[W+7:0], 24'h8001B4, "chained data");
        PEER.select(1'b0);
        $display("test chain done");
    endtask : t_chain

    task automatic t_irq;
        check_bit(int_wire, 1'b1, "interrupt after capture");
        sw[3] = !sw[3];
        tick(5);
        check_bit(int_wire, 1'b0, "no interrupt on change");
        sw[3] = !sw[3];
        tick(5);
        check_bit(int_wire, 1'b1, "interrupt kept after match");
        sw[15] = !sw[15];
        tick(5);
        check_bit(int_wire, 1'b0, "no interrupt on top bit");
        int_enable = 1'b0;
        tick(5);
        check_bit(int_wire, 1'b1, "interrupt while disabled");
        int_enable = 1'b1;
        tick(5);
        check_bit(int_wire, 1'b0, "interrupt lost on enable");
        PEER.select(1'b1);
        check_bit(int_wire, 1'b1, "interrupt not cleared by select");
        PEER.select(1'b0);
        $display("test irq done");
    endtask : t_irq

    task automatic t_ignore;
        PEER.noise(6);
        check_bit(soe, 1'b0, "output driven by noise");
        PEER.select(1'b1);
        PEER.xfer(W, 32'h0, 400, rx);
        check_word(rx[W-1:0], sw, "readback after noise");
        PEER.select(1'b0);
        $display("test ignore done");
    endtask : t_ignore

    // A reset in mid-frame releases both pins; a select still low then
    // counts as a fresh frame once the synchronisers have refilled.
    task automatic t_reset;
        PEER.select(1'b1);
        rst_in = 1'b1;
        tick(2);
        check_bit(soe, 1'b0, "output driven in reset");
        check_bit(int_wire, 1'b1, "interrupt pin pulled in reset");
        rst_in = 1'b0;
        tick(8);
        check_bit(soe, 1'b1, "output not driven after reset");
        check_bit(int_wire, 1'b1, "interrupt left after reset capture");
        PEER.xfer(W, 32'h0, 400, rx);
        check_word(rx[W-1:0], sw, "readback after reset");
        PEER.select(1'b0);
        $display("test reset done");
    endtask : t_reset

    initial begin
        rst_in     = 1'b1;
        sw         = '0;
        int_enable = 1'b1;
        repeat (5) @(posedge clock_in);
        #1 rst_in = 1'b0;
        tick(6);
        t_idle;
        t_read(16'hA5C3, 400);
        t_read(16'h5A3C, 400);
        t_chain;
        t_irq;
        t_ignore;
        t_reset;
        stop_test;
    end

    // The tests need about 94 us; ten times that means a hang.
    initial begin
        #(1_000_000);
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        stop_test;
    end
endmodule : spi_switch_input_shifter_irq_tb
